// >>> hw/pld_pkg.sv
// Package of constants for the loop configuration and lock detect block.
//------------------------------------------------------------------------
// Summary of operation
// - Filter resistor R3 codes 0..4 give 200R to 16k; 5..7 reserved.
// - First-loop feedback path delay is code times 205 ps.
// - First-loop reference path delay is code times 205 ps.
// - First-loop lock window codes 0..3 give 5.5, 10, 18.6, 40 ns.
// - First-loop lock counter counts comparisons with error below window.
// - DAC update divides first-loop comparisons by 1..1023; 0 reserved.
// - First-loop lock asserts after count good comparisons; 0 reserved.
// - Second-loop lock counter counts comparisons with error below window.
// - Doubler bit set doubles second-loop reference; clear passes it.
// - Pump codes give 100, 400, 1600, 3200 uA; none when tri-stated.
// - Second-loop lock asserts after count good comparisons; 0 reserved.
// - Pump pin tri-stated when tri-state bit is one, else active.
//------------------------------------------------------------------------
package pld_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0] PLD_FILT_DLY_OFS = 8'h00;
    localparam logic [7:0] PLD_DAC_LK1_OFS = 8'h04;
    localparam logic [7:0] PLD_LK2_PUMP_OFS = 8'h08;
    localparam logic [7:0] PLD_IRQ_STAT_OFS = 8'h0c;
    localparam logic [7:0] PLD_IRQ_MASK_OFS = 8'h10;
    localparam logic [7:0] PLD_LOCK_STAT_OFS = 8'h14;
    // Field positions.
    localparam int PLD_R3_LSB = 16;
    localparam int PLD_FBDLY_LSB = 12;
    localparam int PLD_REFDLY_LSB = 8;
    localparam int PLD_WIN1_LSB = 6;
    localparam int PLD_DACDIV_LSB = 22;
    localparam int PLD_CNT_LSB = 6;
    localparam int PLD_WIN2_LSB = 30;
    localparam int PLD_DBL_BIT = 29;
    localparam int PLD_POL_BIT = 28;
    localparam int PLD_GAIN_LSB = 26;
    localparam int PLD_TRI_BIT = 5;
    // Writable bits of each configuration register.
    localparam logic [31:0] PLD_FILT_DLY_MASK = 32'h000777c0;
    localparam logic [31:0] PLD_DAC_LK1_MASK = 32'hffcfffc0;
    localparam logic [31:0] PLD_LK2_PUMP_MASK = 32'hfc0fffe0;
    // Values after reset.
    localparam logic [31:0] PLD_FILT_DLY_RST = 32'h00000000;
    localparam logic [31:0] PLD_DAC_LK1_RST = 32'h00400040;
    localparam logic [31:0] PLD_LK2_PUMP_RST = 32'h80000060;
    // Delay step and window sizes in picoseconds.
    localparam int PLD_DLY_STEP_PS = 205;
    localparam logic [15:0] PLD_WIN_5P5_PS = 16'd5500;
    localparam logic [15:0] PLD_WIN_10_PS = 16'd10000;
    localparam logic [15:0] PLD_WIN_18P6_PS = 16'd18600;
    localparam logic [15:0] PLD_WIN_40_PS = 16'd40000;
    localparam logic [15:0] PLD_WIN_3P7_PS = 16'd3700;
    localparam logic [1:0] PLD_WIN2_CODE = 2'h2;
    // Pump currents in microamperes.
    localparam logic [11:0] PLD_PUMP_100_UA = 12'd100;
    localparam logic [11:0] PLD_PUMP_400_UA = 12'd400;
    localparam logic [11:0] PLD_PUMP_1600_UA = 12'd1600;
    localparam logic [11:0] PLD_PUMP_3200_UA = 12'd3200;
    // Highest valid filter resistor code.
    localparam logic [2:0] PLD_R3_MAX_CODE = 3'h4;
    // Interrupt status bits.
    localparam int PLD_IRQ_W = 4;
    localparam int PLD_EV_LOCK1 = 0;
    localparam int PLD_EV_UNLOCK1 = 1;
    localparam int PLD_EV_LOCK2 = 2;
    localparam int PLD_EV_UNLOCK2 = 3;
endpackage

// >>> hw/pld_lock_detect.sv
// Digital lock detector for one loop: window compare and lock counter.
`timescale 1ns/1ps
module pld_lock_detect
    import pld_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic cmp_stb, // One pulse per phase comparison.
    input wire logic [15:0] phase_err_ps, // Magnitude of phase error.
    input wire logic [15:0] window_ps, // Selected window, zero if reserved.
    input wire logic [13:0] lock_cnt, // Comparisons needed for lock.
    output logic locked_r, // Digital lock indication.
    output logic [13:0] count_r // Current lock counter value.
);

    logic in_window;

    // A comparison is good only when the error is strictly below the window.
    assign in_window = phase_err_ps < window_ps;

    // Counter saturates at its top so a long lock never wraps.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= 14'h0000;
        end else if (cmp_stb) begin
            if (!in_window) begin
                count_r <= 14'h0000;
            end else if (count_r != 14'h3fff) begin
                count_r <= count_r + 14'h0001;
            end
        end
    end

    // Lock rises on the comparison that reaches the count; code 0 never locks.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            locked_r <= 1'b0;
        end else if (cmp_stb) begin
            if (!in_window || lock_cnt == 14'h0000) begin
                locked_r <= 1'b0;
            end else if (count_r + 14'h0001 >= lock_cnt ||
                         count_r == 14'h3fff) begin
                locked_r <= 1'b1;
            end
        end
    end

endmodule

// >>> hw/pld_top.sv
// Register bank, lock detectors and loop controls with a Wishbone slave.
`timescale 1ns/1ps
module pld_top
    import pld_pkg::*;
(
    input wire logic SYS_CLK, // 100 MHz system clock.
    input wire logic ARST_N, // Asynchronous reset, active low.
    input wire logic WB_CYC_I, // Wishbone cycle.
    input wire logic WB_STB_I, // Wishbone strobe.
    input wire logic WB_WE_I, // Wishbone write enable.
    input wire logic [7:0] WB_ADR_I, // Wishbone byte address.
    input wire logic [3:0] WB_SEL_I, // Wishbone byte selects.
    input wire logic [31:0] WB_DAT_I, // Wishbone write data.
    output logic [31:0] WB_DAT_O, // Wishbone read data.
    output logic WB_ACK_O, // Wishbone acknowledge.
    input wire logic LOOP1_CMP_STB, // First-loop comparison pulse.
    input wire logic [15:0] LOOP1_PHASE_ERR_PS, // First-loop error.
    input wire logic LOOP2_CMP_STB, // Second-loop comparison pulse.
    input wire logic [15:0] LOOP2_PHASE_ERR_PS, // Second-loop error.
    input wire logic LOOP2_REF_STB, // Second-loop reference edge pulse.
    output logic LOOP2_PD_REF_STB, // Reference edges seen by detector.
    output logic LOOP1_LOCKED, // First-loop digital lock.
    output logic LOOP2_LOCKED, // Second-loop digital lock.
    output logic DAC_UPDATE_STB, // Tuning DAC update enable pulse.
    output logic [4:0] FILTER_R3_SEL, // One-hot R3 select, 0 if reserved.
    output logic [10:0] LOOP1_FB_DELAY_PS, // Feedback path delay.
    output logic [10:0] LOOP1_REF_DELAY_PS, // Reference path delay.
    output logic LOOP2_REF_DOUBLE, // Reference doubler engaged.
    output logic LOOP2_PUMP_POS, // Pump polarity, 1 is positive.
    output logic [11:0] LOOP2_PUMP_UA, // Pump current, 0 when off.
    output logic LOOP2_PUMP_OE, // Pump pin drive enable.
    output logic IRQ // Level interrupt.
);

    //--------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------
    logic [31:0] filt_dly_r;
    logic [31:0] dac_lk1_r;
    logic [31:0] lk2_pump_r;
    logic [PLD_IRQ_W-1:0] irq_stat_r;
    logic [PLD_IRQ_W-1:0] irq_mask_r;
    logic [PLD_IRQ_W-1:0] irq_event;
    logic [31:0] wmask;
    logic [31:0] rd_nxt;
    logic bus_req;
    logic bus_wr;
    logic [15:0] win1_ps;
    logic [15:0] win2_ps;
    logic lock1;
    logic lock2;
    logic lock1_q_r;
    logic lock2_q_r;
    logic [13:0] cnt1;
    logic [13:0] cnt2;
    logic [9:0] dac_div_cnt_r;
    logic [9:0] dac_div;
    logic [2:0] r3_code;
    logic [2:0] fb_code;
    logic [2:0] ref_code;
    logic dbl_phase_r;

    //--------------------------------------------------------------------
    // Wishbone slave
    //--------------------------------------------------------------------

    // A request is taken once; ack drops in the cycle after it was given.
    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign bus_wr = bus_req && WB_WE_I;

    // Byte selects widen into a bit mask for the write merge.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{WB_SEL_I[i]}};
        end
    end

    // Acknowledge every access, mapped or not, one cycle after the request.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= bus_req;
        end
    end

    // Read multiplexer; unmapped addresses and unused bits read as zero.
    always_comb begin
        case (WB_ADR_I)
            PLD_FILT_DLY_OFS: rd_nxt = filt_dly_r;
            PLD_DAC_LK1_OFS: rd_nxt = dac_lk1_r;
            PLD_LK2_PUMP_OFS: rd_nxt = lk2_pump_r;
            PLD_IRQ_STAT_OFS: rd_nxt = {28'h0000000, irq_stat_r};
            PLD_IRQ_MASK_OFS: rd_nxt = {28'h0000000, irq_mask_r};
            PLD_LOCK_STAT_OFS: rd_nxt = {cnt2, 2'h0, cnt1,
                                         lock2_q_r, lock1_q_r};
            default: rd_nxt = 32'h00000000;
        endcase
    end

    // Read data is registered with the acknowledge.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WB_DAT_O <= 32'h00000000;
        end else if (bus_req && !WB_WE_I) begin
            WB_DAT_O <= rd_nxt;
        end
    end

    //--------------------------------------------------------------------
    // Configuration registers
    //--------------------------------------------------------------------

    // Filter and delay register.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            filt_dly_r <= PLD_FILT_DLY_RST;
        end else if (bus_wr && WB_ADR_I == PLD_FILT_DLY_OFS) begin
            filt_dly_r <= ((filt_dly_r & ~wmask) | (WB_DAT_I & wmask))
                          & PLD_FILT_DLY_MASK;
        end
    end

    // DAC divider and first-loop lock count register.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dac_lk1_r <= PLD_DAC_LK1_RST;
        end else if (bus_wr && WB_ADR_I == PLD_DAC_LK1_OFS) begin
            dac_lk1_r <= ((dac_lk1_r & ~wmask) | (WB_DAT_I & wmask))
                         & PLD_DAC_LK1_MASK;
        end
    end

    // Second-loop lock and pump register; the window code is stored as
    // written, software keeps it at the one legal code.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lk2_pump_r <= PLD_LK2_PUMP_RST;
        end else if (bus_wr && WB_ADR_I == PLD_LK2_PUMP_OFS) begin
            lk2_pump_r <= ((lk2_pump_r & ~wmask) | (WB_DAT_I & wmask))
                          & PLD_LK2_PUMP_MASK;
        end
    end

    //--------------------------------------------------------------------
    // Field decode
    //--------------------------------------------------------------------
    assign r3_code = filt_dly_r[PLD_R3_LSB +: 3];
    assign fb_code = filt_dly_r[PLD_FBDLY_LSB +: 3];
    assign ref_code = filt_dly_r[PLD_REFDLY_LSB +: 3];
    assign dac_div = dac_lk1_r[PLD_DACDIV_LSB +: 10];

    // First-loop window from its two-bit code.
    always_comb begin
        case (filt_dly_r[PLD_WIN1_LSB +: 2])
            2'h0: win1_ps = PLD_WIN_5P5_PS;
            2'h1: win1_ps = PLD_WIN_10_PS;
            2'h2: win1_ps = PLD_WIN_18P6_PS;
            default: win1_ps = PLD_WIN_40_PS;
        endcase
    end

    // Second-loop window; reserved codes give an empty window, so no lock.
    always_comb begin
        case (lk2_pump_r[PLD_WIN2_LSB +: 2])
            PLD_WIN2_CODE: win2_ps = PLD_WIN_3P7_PS;
            default: win2_ps = 16'h0000;
        endcase
    end

    //--------------------------------------------------------------------
    // Lock detectors
    //--------------------------------------------------------------------
    pld_lock_detect u_lock1 (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .cmp_stb(LOOP1_CMP_STB),
        .phase_err_ps(LOOP1_PHASE_ERR_PS),
        .window_ps(win1_ps),
        .lock_cnt(dac_lk1_r[PLD_CNT_LSB +: 14]),
        .locked_r(lock1),
        .count_r(cnt1)
    );

    pld_lock_detect u_lock2 (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .cmp_stb(LOOP2_CMP_STB),
        .phase_err_ps(LOOP2_PHASE_ERR_PS),
        .window_ps(win2_ps),
        .lock_cnt(lk2_pump_r[PLD_CNT_LSB +: 14]),
        .locked_r(lock2),
        .count_r(cnt2)
    );

    // Delayed lock copies drive the pins and feed the edge events.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lock1_q_r <= 1'b0;
            lock2_q_r <= 1'b0;
        end else begin
            lock1_q_r <= lock1;
            lock2_q_r <= lock2;
        end
    end

    assign LOOP1_LOCKED = lock1_q_r;
    assign LOOP2_LOCKED = lock2_q_r;

    //--------------------------------------------------------------------
    // Interrupts
    //--------------------------------------------------------------------
    assign irq_event[PLD_EV_LOCK1] = lock1 && !lock1_q_r;
    assign irq_event[PLD_EV_UNLOCK1] = !lock1 && lock1_q_r;
    assign irq_event[PLD_EV_LOCK2] = lock2 && !lock2_q_r;
    assign irq_event[PLD_EV_UNLOCK2] = !lock2 && lock2_q_r;

    // Sticky status, cleared by writing one; a new event beats the clear.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_stat_r <= '0;
        end else if (bus_wr && WB_ADR_I == PLD_IRQ_STAT_OFS &&
                     WB_SEL_I[0]) begin
            irq_stat_r <= (irq_stat_r & ~WB_DAT_I[PLD_IRQ_W-1:0]) | irq_event;
        end else begin
            irq_stat_r <= irq_stat_r | irq_event;
        end
    end

    // Mask register, one enables the matching status bit.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_mask_r <= '0;
        end else if (bus_wr && WB_ADR_I == PLD_IRQ_MASK_OFS &&
                     WB_SEL_I[0]) begin
            irq_mask_r <= WB_DAT_I[PLD_IRQ_W-1:0];
        end
    end

    // Interrupt output follows the masked status one cycle later.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_r & irq_mask_r);
        end
    end

    //--------------------------------------------------------------------
    // DAC update divider
    //--------------------------------------------------------------------

    // Counts first-loop comparisons; divisor 0 stops the update pulses.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dac_div_cnt_r <= 10'h000;
            DAC_UPDATE_STB <= 1'b0;
        end else begin
            DAC_UPDATE_STB <= 1'b0;
            if (dac_div == 10'h000) begin
                dac_div_cnt_r <= 10'h000;
            end else if (LOOP1_CMP_STB) begin
                if (dac_div_cnt_r + 10'h001 >= dac_div) begin
                    dac_div_cnt_r <= 10'h000;
                    DAC_UPDATE_STB <= 1'b1;
                end else begin
                    dac_div_cnt_r <= dac_div_cnt_r + 10'h001;
                end
            end
        end
    end

    //--------------------------------------------------------------------
    // Reference doubler
    //--------------------------------------------------------------------

    // Each reference pulse is passed, and when doubling a second pulse
    // follows one cycle later, so the detector sees twice the edges.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dbl_phase_r <= 1'b0;
            LOOP2_PD_REF_STB <= 1'b0;
        end else begin
            dbl_phase_r <= LOOP2_REF_STB && lk2_pump_r[PLD_DBL_BIT];
            LOOP2_PD_REF_STB <= LOOP2_REF_STB || dbl_phase_r;
        end
    end

    //--------------------------------------------------------------------
    // Analog control outputs
    //--------------------------------------------------------------------

    // Filter resistor select, delays, doubler and polarity.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            FILTER_R3_SEL <= 5'h00;
            LOOP1_FB_DELAY_PS <= 11'h000;
            LOOP1_REF_DELAY_PS <= 11'h000;
            LOOP2_REF_DOUBLE <= 1'b0;
            LOOP2_PUMP_POS <= 1'b0;
        end else begin
            if (r3_code <= PLD_R3_MAX_CODE) begin
                FILTER_R3_SEL <= 5'(5'h01 << r3_code);
            end else begin
                FILTER_R3_SEL <= 5'h00;
            end
            LOOP1_FB_DELAY_PS <= 11'(fb_code * PLD_DLY_STEP_PS);
            LOOP1_REF_DELAY_PS <= 11'(ref_code * PLD_DLY_STEP_PS);
            LOOP2_REF_DOUBLE <= lk2_pump_r[PLD_DBL_BIT];
            LOOP2_PUMP_POS <= lk2_pump_r[PLD_POL_BIT];
        end
    end

    // Pump current and pin enable; tri-state overrides the current code.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            LOOP2_PUMP_UA <= 12'h000;
            LOOP2_PUMP_OE <= 1'b0;
        end else if (lk2_pump_r[PLD_TRI_BIT]) begin
            LOOP2_PUMP_UA <= 12'h000;
            LOOP2_PUMP_OE <= 1'b0;
        end else begin
            LOOP2_PUMP_OE <= 1'b1;
            case (lk2_pump_r[PLD_GAIN_LSB +: 2])
                2'h0: LOOP2_PUMP_UA <= PLD_PUMP_100_UA;
                2'h1: LOOP2_PUMP_UA <= PLD_PUMP_400_UA;
                2'h2: LOOP2_PUMP_UA <= PLD_PUMP_1600_UA;
                default: LOOP2_PUMP_UA <= PLD_PUMP_3200_UA;
            endcase
        end
    end

endmodule

// >>> testbench/pld_asserts.sv
// Port-level checker for the loop configuration and lock detect block.
`timescale 1ns/1ps
module pld_asserts
    import pld_pkg::*;
(
    input wire logic SYS_CLK, // Clock.
    input wire logic ARST_N, // Reset, active low.
    input wire logic LOOP1_CMP_STB, // First-loop comparison.
    input wire logic [15:0] LOOP1_PHASE_ERR_PS, // First-loop error.
    input wire logic LOOP2_CMP_STB, // Second-loop comparison.
    input wire logic [15:0] LOOP2_PHASE_ERR_PS, // Second-loop error.
    input wire logic LOOP2_REF_STB, // Reference edge.
    input wire logic LOOP2_PD_REF_STB, // Edges at the detector.
    input wire logic LOOP1_LOCKED, // First-loop lock.
    input wire logic LOOP2_LOCKED, // Second-loop lock.
    input wire logic DAC_UPDATE_STB, // DAC update pulse.
    input wire logic [4:0] FILTER_R3_SEL, // Resistor select.
    input wire logic [10:0] LOOP1_FB_DELAY_PS, // Feedback delay.
    input wire logic [10:0] LOOP1_REF_DELAY_PS, // Reference delay.
    input wire logic [11:0] LOOP2_PUMP_UA, // Pump current.
    input wire logic LOOP2_PUMP_OE // Pump drive enable.
);
    //----------------------------------------------------------------
    // Checks
    //----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    a_r3_onehot: assert property ($onehot0(FILTER_R3_SEL))
        else $error("Resistor select has more than one bit set.");
    a_fb_delay_step: assert property (LOOP1_FB_DELAY_PS % 205 == 0
        && LOOP1_FB_DELAY_PS <= 11'd1435)
        else $error("Feedback delay is not a whole step.");
    a_ref_delay_step: assert property (
        LOOP1_REF_DELAY_PS % 205 == 0 && LOOP1_REF_DELAY_PS <= 11'd1435)
        else $error("Reference delay is not a whole step.");
    a_pump_off_zero: assert property (
        !LOOP2_PUMP_OE |-> LOOP2_PUMP_UA == 0)
        else $error("Pump current while tri-stated.");
    a_pump_on_level: assert property (
        LOOP2_PUMP_OE |-> LOOP2_PUMP_UA inside
        {12'd100, 12'd400, 12'd1600, 12'd3200})
        else $error("Pump current is not a legal level.");
    a_lock1_rise_cause: assert property (
        $rose(LOOP1_LOCKED) |-> $past(LOOP1_CMP_STB, 2))
        else $error("First-loop lock rose without a comparison.");
    a_lock2_rise_cause: assert property (
        $rose(LOOP2_LOCKED) |-> $past(LOOP2_CMP_STB, 2))
        else $error("Second-loop lock rose without a comparison.");
    a_lock1_drop_err: assert property (
        LOOP1_CMP_STB && LOOP1_PHASE_ERR_PS >= PLD_WIN_40_PS
        |-> ##2 !LOOP1_LOCKED)
        else $error("First-loop lock held after a large error.");
    a_lock2_drop_err: assert property (
        LOOP2_CMP_STB && LOOP2_PHASE_ERR_PS >= PLD_WIN_3P7_PS
        |-> ##2 !LOOP2_LOCKED)
        else $error("Second-loop lock held after a large error.");
    a_dac_after_cmp: assert property (
        DAC_UPDATE_STB |-> $past(LOOP1_CMP_STB))
        else $error("DAC update without a comparison.");
    a_ref_edge_pass: assert property (
        LOOP2_REF_STB |=> LOOP2_PD_REF_STB)
        else $error("Reference edge lost before the detector.");
    c_lock1: cover property ($rose(LOOP1_LOCKED));
    c_lock2: cover property ($rose(LOOP2_LOCKED));
    c_dac: cover property (DAC_UPDATE_STB);
endmodule

bind pld_top pld_asserts u_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
    .LOOP1_CMP_STB(LOOP1_CMP_STB), .LOOP1_PHASE_ERR_PS(LOOP1_PHASE_ERR_PS),
    .LOOP2_CMP_STB(LOOP2_CMP_STB), .LOOP2_PHASE_ERR_PS(LOOP2_PHASE_ERR_PS),
    .LOOP2_REF_STB(LOOP2_REF_STB), .LOOP2_PD_REF_STB(LOOP2_PD_REF_STB),
    .LOOP1_LOCKED(LOOP1_LOCKED), .LOOP2_LOCKED(LOOP2_LOCKED),
    .DAC_UPDATE_STB(DAC_UPDATE_STB), .FILTER_R3_SEL(FILTER_R3_SEL),
    .LOOP1_FB_DELAY_PS(LOOP1_FB_DELAY_PS),
    .LOOP1_REF_DELAY_PS(LOOP1_REF_DELAY_PS),
    .LOOP2_PUMP_UA(LOOP2_PUMP_UA), .LOOP2_PUMP_OE(LOOP2_PUMP_OE));

// >>> testbench/pld_tb.sv
// Self-checking bench for the loop configuration and lock detect block.
`timescale 1ns/1ps
module testbench;
    import pld_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic s1 = 1'b0, s2 = 1'b0, rs = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat_w = 32'h0, dat_r, q;
    logic [15:0] e1 = 16'h0, e2 = 16'h0;
    logic ack, pd, lk1, lk2, dacs, dbl, pos, oe, irq;
    logic [4:0] r3;
    logic [10:0] fbd, rfd;
    logic [11:0] ua;
    logic [15:0] win [4] = '{PLD_WIN_5P5_PS, PLD_WIN_10_PS,
        PLD_WIN_18P6_PS, PLD_WIN_40_PS};
    logic [11:0] cur [4] = '{PLD_PUMP_100_UA, PLD_PUMP_400_UA,
        PLD_PUMP_1600_UA, PLD_PUMP_3200_UA};
    int n_fail = 0, compares = 0, n_dac = 0, n_pd = 0;

    pld_top dut (.SYS_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
        .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
        .LOOP1_CMP_STB(s1), .LOOP1_PHASE_ERR_PS(e1), .LOOP2_CMP_STB(s2),
        .LOOP2_PHASE_ERR_PS(e2), .LOOP2_REF_STB(rs), .LOOP2_PD_REF_STB(pd),
        .LOOP1_LOCKED(lk1), .LOOP2_LOCKED(lk2), .DAC_UPDATE_STB(dacs),
        .FILTER_R3_SEL(r3), .LOOP1_FB_DELAY_PS(fbd),
        .LOOP1_REF_DELAY_PS(rfd), .LOOP2_REF_DOUBLE(dbl),
        .LOOP2_PUMP_POS(pos), .LOOP2_PUMP_UA(ua), .LOOP2_PUMP_OE(oe),
        .IRQ(irq));

    // The clock toggles every half period of 5 ns.
    always #5 clk = ~clk;

    // Pulse counters for the DAC update and detector reference edges.
    always @(posedge clk) begin
        if (dacs === 1'b1) n_dac <= n_dac + 1;
        if (pd === 1'b1) n_pd <= n_pd + 1;
    end

    //----------------------------------------------------------------
    // Helpers
    //----------------------------------------------------------------
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One classic bus cycle; read data lands in q.
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // Back-to-back comparison strobes on one loop.
    task automatic pls(input logic two, input logic [15:0] e, input int n);
        @(posedge clk);
        s1 <= !two;
        s2 <= two;
        e1 <= e;
        e2 <= e;
        repeat (n) @(posedge clk);
        s1 <= 1'b0;
        s2 <= 1'b0;
        wt(2);
    endtask

    //----------------------------------------------------------------
    // Scenarios
    //----------------------------------------------------------------
    task automatic t_reset();
        wb(1'b0, PLD_FILT_DLY_OFS, 32'h0);
        chk(q, PLD_FILT_DLY_RST);
        wb(1'b0, PLD_DAC_LK1_OFS, 32'h0);
        chk(q, PLD_DAC_LK1_RST);
        wb(1'b0, PLD_LK2_PUMP_OFS, 32'h0);
        chk(q, PLD_LK2_PUMP_RST);
        chk(oe, 1'b0);
        wb(1'b1, 8'h18, 32'hffffffff);
        wb(1'b0, 8'h18, 32'h0);
        chk(q, 32'h0);
        $display("Test reset and map done");
    endtask

    task automatic t_cfg();
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, PLD_FILT_DLY_OFS, (c << 16) | (c << 12) | (c << 8));
            wt(2);
            chk(r3, c < 5 ? 1 << c : 0);
            chk(fbd, c * PLD_DLY_STEP_PS);
            chk(rfd, c * PLD_DLY_STEP_PS);
        end
        $display("Test filter and delays done");
    endtask

    task automatic t_pump();
        int base;
        for (int g = 0; g < 8; g++) begin
            wb(1'b1, PLD_LK2_PUMP_OFS, 32'h80000040 | ((g & 3) << 26) |
                (g[2] << 5) | (g[1] << 29) | (g[0] << 28));
            base = n_pd;
            @(posedge clk);
            rs <= 1'b1;
            @(posedge clk);
            rs <= 1'b0;
            wt(3);
            chk(ua, g[2] ? 12'd0 : cur[g & 3]);
            chk(oe, !g[2]);
            chk(pos, g[0]);
            chk(n_pd - base, g[1] ? 2 : 1);
            chk(dbl, g[1]);
        end
        $display("Test pump and doubler done");
    endtask

    task automatic t_lock1();
        int base;
        wb(1'b1, PLD_DAC_LK1_OFS, (1 << 22) | (3 << 6));
        for (int w = 0; w < 4; w++) begin
            wb(1'b1, PLD_IRQ_MASK_OFS, w != 3);
            wb(1'b1, PLD_FILT_DLY_OFS, w << 6);
            pls(1'b0, win[w] - 16'd1, 2);
            chk(lk1, 1'b0);
            pls(1'b0, win[w] - 16'd1, 1);
            chk(lk1, 1'b1);
            chk(irq, w != 3);
            wb(1'b1, PLD_IRQ_STAT_OFS, 32'hf);
            wt(1);
            chk(irq, 1'b0);
            pls(1'b0, win[w], 1);
            chk(lk1, 1'b0);
        end
        wb(1'b1, PLD_DAC_LK1_OFS, (3 << 22) | (1 << 6));
        base = n_dac;
        pls(1'b0, 16'h0, 9);
        chk(n_dac - base, 3);
        wb(1'b1, PLD_DAC_LK1_OFS, 1 << 22);
        pls(1'b0, 16'h0, 4);
        chk(lk1, 1'b0);
        $display("Test first-loop lock done");
    endtask

    task automatic t_lock2();
        wb(1'b1, PLD_LK2_PUMP_OFS, 32'h80000080);
        pls(1'b1, PLD_WIN_3P7_PS - 16'd1, 1);
        chk(lk2, 1'b0);
        pls(1'b1, PLD_WIN_3P7_PS - 16'd1, 1);
        chk(lk2, 1'b1);
        // Counts: loop 2 at two, loop 1 at thirteen from the earlier test.
        wb(1'b0, PLD_LOCK_STAT_OFS, 32'h0);
        chk(q, (2 << 18) | (13 << 2) | 2);
        pls(1'b1, PLD_WIN_3P7_PS, 1);
        chk(lk2, 1'b0);
        wb(1'b1, PLD_LK2_PUMP_OFS, 32'h40000080);
        pls(1'b1, 16'h0, 4);
        chk(lk2, 1'b0);
        $display("Test second-loop lock done");
    endtask

    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence after a reset of three cycles.
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_cfg();
        t_pump();
        t_lock1();
        t_lock2();
        tally_and_finish();
    end

    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
endmodule
